// >>> verilog/fsr_pkg.sv
package fsr_pkg;

  // ==========================================================================
  // Register map (byte addresses on the APB)
  localparam logic [7:0] FSR_ADDR_SR1P   = 8'h00;
  localparam logic [7:0] FSR_ADDR_SR1W   = 8'h04;
  localparam logic [7:0] FSR_ADDR_SR2W   = 8'h08;
  localparam logic [7:0] FSR_ADDR_CFG1   = 8'h0C;
  localparam logic [7:0] FSR_ADDR_ENGINE = 8'h10;
  localparam logic [7:0] FSR_ADDR_EVENT  = 8'h14;
  localparam logic [7:0] FSR_ADDR_ISTAT  = 8'h18;
  localparam logic [7:0] FSR_ADDR_IMASK  = 8'h1C;

  // ==========================================================================
  // Field positions
  localparam int FSR_SR1_LOCK   = 7;
  localparam int FSR_SR1_PERR   = 6;
  localparam int FSR_SR1_EERR   = 5;
  localparam int FSR_SR1_BP_HI  = 4;
  localparam int FSR_SR1_BP_LO  = 2;
  localparam int FSR_SR1_WEL    = 1;
  localparam int FSR_SR1_BUSY   = 0;
  localparam int FSR_CFG1_BPNV  = 3;
  localparam int FSR_ENG_BUSY   = 0;
  localparam int FSR_ENG_PHOLD  = 1;
  localparam int FSR_ENG_EHOLD  = 2;
  localparam int FSR_EVT_PFAIL  = 0;
  localparam int FSR_EVT_EFAIL  = 1;
  localparam int FSR_EVT_POK    = 2;
  localparam int FSR_EVT_EOK    = 3;
  localparam int FSR_EVT_EVAL   = 4;
  localparam int FSR_EVT_EVRES  = 5;
  localparam int FSR_IRQ_W      = 5;
  localparam int FSR_IRQ_WEL    = 0;
  localparam int FSR_IRQ_ACC    = 1;
  localparam int FSR_IRQ_REF    = 2;
  localparam int FSR_IRQ_PERR   = 3;
  localparam int FSR_IRQ_EERR   = 4;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] FSR_SR1P_RST = 8'h00;
  localparam logic [2:0] FSR_BP_ALL   = 3'h7;
  localparam logic [4:0] FSR_SR2_RSV  = 5'h00;

  // ==========================================================================
  // Link opcodes
  localparam logic [7:0] FSR_OP_WRITE_REGS = 8'h01;
  localparam logic [7:0] FSR_OP_FORBID     = 8'h04;
  localparam logic [7:0] FSR_OP_READ_SR1   = 8'h05;
  localparam logic [7:0] FSR_OP_ALLOW      = 8'h06;
  localparam logic [7:0] FSR_OP_READ_SR2   = 8'h07;

  typedef struct packed {
    logic       lock;
    logic       perr;
    logic       eerr;
    logic [2:0] range;
    logic       write_allow_latch;
    logic       busy;
  } fsr_sr1_s;

  typedef enum logic [1:0] {
    FSR_LK_IDLE = 2'b00,
    FSR_LK_OP   = 2'b01,
    FSR_LK_DATA = 2'b10
  } fsr_link_e;

endpackage

// >>> verilog/fsr_status_bank.sv
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/100ps
module fsr_status_bank
  import fsr_pkg::*;
#(
  parameter int AW = 8
)
(
  input  wire logic          i_clk,
  input  wire logic          i_rst_n,
  input  wire logic          i_psel,
  input  wire logic          i_penable,
  input  wire logic          i_pwrite,
  input  wire logic [AW-1:0] i_paddr,
  input  wire logic [31:0]   i_pwdata,
  output logic      [31:0]   o_prdata,
  output logic               o_pready,
  output logic               o_pslverr,
  input  wire logic          i_sck,
  input  wire logic          i_cs_n,
  input  wire logic          i_si,
  input  wire logic          i_wp_n,
  output logic               o_so,
  output logic               o_write_allow,
  output logic      [2:0]    o_protect_range,
  output logic               o_irq
);

  if (AW < 5)
  begin : g_aw_check
    $error("AW too small for the register map");
  end

  // ==========================================================================
  // Pin synchronisers
  logic [2:0] sck_q;
  logic [2:0] cs_q;
  logic [1:0] si_q;
  logic [1:0] wp_q;

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      sck_q <= 3'h0;
      cs_q  <= 3'h7;
      si_q  <= 2'h0;
      wp_q  <= 2'h3;
    end
    else
    begin
      sck_q <= {sck_q[1:0], i_sck};
      cs_q  <= {cs_q[1:0], i_cs_n};
      si_q  <= {si_q[0], i_si};
      wp_q  <= {wp_q[0], i_wp_n};
    end
  end

  wire sck_rise = sck_q[1] & ~sck_q[2];
  wire sck_fall = ~sck_q[1] & sck_q[2];
  wire cs_fall  = ~cs_q[1] & cs_q[2];
  wire cs_rise  = cs_q[1] & ~cs_q[2];

  // ==========================================================================
  // Status state
  logic       p_lock_r;
  logic [2:0] p_range_r;
  logic [2:0] w_range_r;
  logic       wel_r;
  logic       perr_r;
  logic       eerr_r;
  logic       busy_r;
  logic       phold_r;
  logic       ehold_r;
  logic       eval_r;
  logic       bpnv_r;
  logic [FSR_IRQ_W-1:0] istat_r;
  logic [FSR_IRQ_W-1:0] imask_r;

  fsr_sr1_s sr1p;
  fsr_sr1_s sr1w;
  wire [7:0] sr2w = {FSR_SR2_RSV, eval_r, ehold_r, phold_r};

  // Default bits are constants, so no write path can reach them
  assign sr1p.lock  = p_lock_r;
  assign sr1p.perr  = FSR_SR1P_RST[FSR_SR1_PERR];
  assign sr1p.eerr  = FSR_SR1P_RST[FSR_SR1_EERR];
  assign sr1p.range = p_range_r;
  assign sr1p.write_allow_latch   = FSR_SR1P_RST[FSR_SR1_WEL];
  assign sr1p.busy  = FSR_SR1P_RST[FSR_SR1_BUSY];
  wire [2:0] eff_range = bpnv_r ? w_range_r : p_range_r;
  assign sr1w.lock  = p_lock_r;
  assign sr1w.perr  = perr_r;
  assign sr1w.eerr  = eerr_r;
  assign sr1w.range = eff_range;
  assign sr1w.write_allow_latch   = wel_r;
  assign sr1w.busy  = busy_r;

  // ==========================================================================
  // Link receiver (mode 0: sample on rising, shift out on falling)
  fsr_link_e  lk_state_r;
  logic [2:0] bit_cnt_r;
  logic [1:0] dbytes_r;
  logic [7:0] shift_r;
  logic [7:0] opcode_r;
  logic [7:0] wr_data_r;
  logic [7:0] tx_r;
  logic       so_r;

  wire [7:0] shift_nxt = {shift_r[6:0], si_q[1]};
  wire       byte_done = sck_rise && (bit_cnt_r == 3'h7) && (lk_state_r != FSR_LK_IDLE);
  wire       op_read1  = (lk_state_r == FSR_LK_OP) ? (shift_nxt == FSR_OP_READ_SR1)
                                                   : (opcode_r == FSR_OP_READ_SR1);
  wire       op_read2  = (lk_state_r == FSR_LK_OP) ? (shift_nxt == FSR_OP_READ_SR2)
                                                   : (opcode_r == FSR_OP_READ_SR2);
  wire       frame_end = cs_rise && (lk_state_r == FSR_LK_DATA) && (bit_cnt_r == 3'h0);
  wire       do_allow  = frame_end && (opcode_r == FSR_OP_ALLOW) && (dbytes_r == 2'h0);
  wire       do_forbid = frame_end && (opcode_r == FSR_OP_FORBID) && (dbytes_r == 2'h0);
  wire       wr_try    = frame_end && (opcode_r == FSR_OP_WRITE_REGS) && (dbytes_r != 2'h0);
  wire       lock_act  = p_lock_r & ~wp_q[1];
  wire       wr_ok     = wr_try && wel_r && !busy_r && !lock_act;

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      lk_state_r <= FSR_LK_IDLE;
      bit_cnt_r  <= 3'h0;
      dbytes_r   <= 2'h0;
      shift_r    <= 8'h00;
      opcode_r   <= 8'h00;
      wr_data_r  <= 8'h00;
    end
    else if (cs_q[1])
      lk_state_r <= FSR_LK_IDLE;
    else
    begin
      case (lk_state_r)
        FSR_LK_IDLE:
        begin
          if (cs_fall)
          begin
            lk_state_r <= FSR_LK_OP;
            bit_cnt_r  <= 3'h0;
            dbytes_r   <= 2'h0;
          end
        end
        FSR_LK_OP, FSR_LK_DATA:
        begin
          if (sck_rise)
          begin
            shift_r   <= shift_nxt;
            bit_cnt_r <= bit_cnt_r + 3'h1;
          end
          if (byte_done && lk_state_r == FSR_LK_OP)
          begin
            opcode_r   <= shift_nxt;
            lk_state_r <= FSR_LK_DATA;
          end
          else if (byte_done)
          begin
            if (dbytes_r == 2'h0)
              wr_data_r <= shift_nxt;
            if (dbytes_r != 2'h3)
              dbytes_r <= dbytes_r + 2'h1;
          end
        end
        default:
          lk_state_r <= FSR_LK_IDLE;
      endcase
    end
  end

  // Reads shift the chosen register out again after every byte for as long as the clock runs
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      tx_r <= 8'h00;
      so_r <= 1'b0;
    end
    else if (byte_done && op_read1)
      tx_r <= sr1w;
    else if (byte_done && op_read2)
      tx_r <= sr2w;
    else if (sck_fall && !cs_q[1])
    begin
      so_r <= tx_r[7];
      tx_r <= {tx_r[6:0], 1'b0};
    end
  end

  // ==========================================================================
  // APB slave: zero wait states, answer registered in the setup cycle
  wire setup   = i_psel & ~i_penable;
  wire access  = i_psel & i_penable & o_pready;
  wire apb_wr  = access & i_pwrite;
  wire [7:0] a8 = 8'(i_paddr);
  wire hit_sr1p = (a8 == FSR_ADDR_SR1P);
  wire hit_sr1w = (a8 == FSR_ADDR_SR1W);
  wire hit_sr2w = (a8 == FSR_ADDR_SR2W);
  wire hit_cfg1 = (a8 == FSR_ADDR_CFG1);
  wire hit_eng  = (a8 == FSR_ADDR_ENGINE);
  wire hit_evt  = (a8 == FSR_ADDR_EVENT);
  wire hit_ist  = (a8 == FSR_ADDR_ISTAT);
  wire hit_imk  = (a8 == FSR_ADDR_IMASK);
  wire hit_any  = hit_sr1p | hit_sr1w | hit_sr2w | hit_cfg1 | hit_eng | hit_evt | hit_ist
                | hit_imk;
  wire [31:0] rd_mux =
    hit_sr1p ? {24'h0, sr1p} :
    hit_sr1w ? {24'h0, sr1w} :
    hit_sr2w ? {24'h0, sr2w} :
    hit_cfg1 ? {28'h0, bpnv_r, 3'h0} :
    hit_eng  ? {29'h0, ehold_r, phold_r, busy_r} :
    hit_ist  ? {27'h0, istat_r} :
    hit_imk  ? {27'h0, imask_r} : 32'h0;
  wire eng_wr = apb_wr & hit_eng;
  wire evt_wr = apb_wr & hit_evt;
  wire ev_pfail = evt_wr & i_pwdata[FSR_EVT_PFAIL];
  wire ev_efail = evt_wr & i_pwdata[FSR_EVT_EFAIL];
  wire ev_pok   = evt_wr & i_pwdata[FSR_EVT_POK];
  wire ev_eok   = evt_wr & i_pwdata[FSR_EVT_EOK];
  wire ev_eval  = evt_wr & i_pwdata[FSR_EVT_EVAL];
  wire [FSR_IRQ_W-1:0] ev_vec = {ev_efail, ev_pfail, wr_try & ~wr_ok, wr_ok, do_allow};
  wire [FSR_IRQ_W-1:0] w1c    = (apb_wr & hit_ist) ? i_pwdata[FSR_IRQ_W-1:0] : '0;

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_prdata  <= 32'h0;
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end
    else
    begin
      o_prdata  <= setup ? rd_mux : o_prdata;
      o_pready  <= setup;
      o_pslverr <= setup & ~hit_any;
    end
  end

  // ==========================================================================
  // Status updates
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      p_lock_r  <= FSR_SR1P_RST[FSR_SR1_LOCK];
      p_range_r <= FSR_SR1P_RST[FSR_SR1_BP_HI:FSR_SR1_BP_LO];
      bpnv_r    <= 1'b0;
    end
    else
    begin
      if (wr_ok)
        p_lock_r <= wr_data_r[FSR_SR1_LOCK];
      if (bpnv_r)
        p_range_r <= FSR_BP_ALL;
      else if (wr_ok)
        p_range_r <= wr_data_r[FSR_SR1_BP_HI:FSR_SR1_BP_LO];
      // One-time bit: it can be set but never cleared
      if (apb_wr && hit_cfg1 && i_pwdata[FSR_CFG1_BPNV])
        bpnv_r <= 1'b1;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      w_range_r <= FSR_SR1P_RST[FSR_SR1_BP_HI:FSR_SR1_BP_LO];
      wel_r     <= FSR_SR1P_RST[FSR_SR1_WEL];
      perr_r    <= FSR_SR1P_RST[FSR_SR1_PERR];
      eerr_r    <= FSR_SR1P_RST[FSR_SR1_EERR];
      busy_r    <= FSR_SR1P_RST[FSR_SR1_BUSY];
      phold_r   <= 1'b0;
      ehold_r   <= 1'b0;
      eval_r    <= 1'b0;
    end
    else
    begin
      // Tracking the persistent range keeps protection unchanged at the mode switch
      if (wr_ok && bpnv_r)
        w_range_r <= wr_data_r[FSR_SR1_BP_HI:FSR_SR1_BP_LO];
      else if (!bpnv_r)
        w_range_r <= p_range_r;
      if (do_allow)
        wel_r <= 1'b1;
      else if (do_forbid)
        wel_r <= 1'b0;
      perr_r <= ev_pfail | (perr_r & ~ev_pok);
      eerr_r <= ev_efail | (eerr_r & ~ev_eok);
      if (eng_wr)
      begin
        busy_r  <= i_pwdata[FSR_ENG_BUSY];
        phold_r <= i_pwdata[FSR_ENG_PHOLD];
        ehold_r <= i_pwdata[FSR_ENG_EHOLD];
      end
      if (ev_eval)
        eval_r <= i_pwdata[FSR_EVT_EVRES];
    end
  end

  // Set wins over a simultaneous write-one-to-clear
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      istat_r         <= '0;
      imask_r         <= '0;
      o_so            <= 1'b0;
      o_write_allow   <= 1'b0;
      o_protect_range <= 3'h0;
      o_irq           <= 1'b0;
    end
    else
    begin
      istat_r         <= (istat_r & ~w1c) | ev_vec;
      imask_r         <= (apb_wr & hit_imk) ? i_pwdata[FSR_IRQ_W-1:0] : imask_r;
      o_so            <= so_r;
      o_write_allow   <= wel_r;
      o_protect_range <= eff_range;
      o_irq           <= |(istat_r & imask_r);
    end
  end

  // ==========================================================================
  // Assertions
  a_lock_refuse: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (wr_try && lock_act && !bpnv_r) |=> $stable(p_range_r) && $stable(p_lock_r))
    else $error("locked register write changed state");
  a_default_fixed: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (setup && hit_sr1p) |=> o_prdata[1:0] == FSR_SR1P_RST[1:0]
      && o_prdata[6:5] == FSR_SR1P_RST[6:5])
    else $error("default bits not constant");
  a_err_sets: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    ev_pfail |=> perr_r ##1 o_irq || !imask_r[FSR_IRQ_PERR] || !istat_r[FSR_IRQ_PERR])
    else $error("program failure not flagged");
  a_nv_range: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    !bpnv_r |=> o_protect_range == $past(p_range_r))
    else $error("range does not follow persistent bits");
  a_force_ones: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    bpnv_r |=> p_range_r == FSR_BP_ALL)
    else $error("persistent range not forced to ones");
  a_vol_write: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (wr_ok && bpnv_r) |=> ##1
      o_protect_range == $past(wr_data_r[FSR_SR1_BP_HI:FSR_SR1_BP_LO], 2))
    else $error("volatile range write lost");
  a_lock_mirror: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (setup && hit_sr1w) |=> o_prdata[7] == $past(p_lock_r))
    else $error("working lock bit differs");
  a_wel_gate: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (wr_try && !wel_r) |=> $stable(p_lock_r))
    else $error("write accepted with latch clear");
  a_wel_cause: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    $changed(wel_r) |-> $past(do_allow) || $past(do_forbid))
    else $error("latch changed without allow or forbid");
  a_busy_cause: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    $changed(busy_r) |-> $past(eng_wr))
    else $error("busy changed without engine update");
  a_sr2_reserved: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (setup && hit_sr2w) |=> o_prdata[7:3] == 5'h0)
    else $error("reserved bits not zero");

endmodule

// >>> test/fsr_host_model.sv
`timescale 1ns/100ps
// ==========================================================================
// Host end of the serial link: mode 0, MSB first
module fsr_host_model (
  input  wire logic i_clk,
  output logic      o_sck,
  output logic      o_cs_n,
  output logic      o_si,
  input  wire logic i_so
);
  // Link clock stands low between frames
  initial
  begin
    o_sck  = 1'b0;
    o_cs_n = 1'b1;
    o_si   = 1'b1;
  end

  // Eight system clocks a half period give the 160 ns link clock
  task automatic half();
    repeat (8) @(posedge i_clk);
  endtask

  task automatic xfer(input logic [23:0] bits, input int n, output logic [7:0] rd);
    rd = 8'h00;
    @(posedge i_clk);
    o_cs_n <= 1'b0;
    for (int k = 0; k < n; k++)
    begin
      o_si <= bits[23-k];
      half();
      o_sck <= 1'b1;
      if (k >= 8 && k < 16)
        rd = {rd[6:0], i_so};
      half();
      o_sck <= 1'b0;
    end
    half();
    o_cs_n <= 1'b1;
    // Released line toggles so a stale bit never passes for data
    o_si   <= ~o_si;
    repeat (8) @(posedge i_clk);
  endtask
endmodule

// >>> test/fsr_status_bank_tb.sv
`timescale 1ns/100ps
module fsr_status_bank_tb
  import fsr_pkg::*;
;
  logic        clk     = 1'b0;
  logic        rst_n   = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        serr;
  logic        sck;
  logic        cs_n;
  logic        si;
  logic        so;
  logic        wp_n    = 1'b1;
  logic        wallow;
  logic [2:0]  prange;
  logic        irq;
  int          err_total   = 0;
  int          checks_done = 0;

  always #5 clk = ~clk;

  fsr_status_bank #(.AW(8)) i_fsr_status_bank (
    .i_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_sck(sck), .i_cs_n(cs_n),
    .i_si(si), .i_wp_n(wp_n), .o_so(so), .o_write_allow(wallow),
    .o_protect_range(prange), .o_irq(irq)
  );

  fsr_host_model i_fsr_host_model (
    .i_clk(clk), .o_sck(sck), .o_cs_n(cs_n), .o_si(si), .i_so(so)
  );

  // ==========================================================================
  // Shared tasks
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      err_total++;
    rd      = prdata;
    serr    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    apb(1'b1, a, d, x);
  endtask

  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    apb(1'b0, a, 32'h0000_0000, x);
    chk(nm, e, x);
  endtask

  task automatic lk(input logic [23:0] b, input int n);
    logic [7:0] x;
    i_fsr_host_model.xfer(b, n, x);
  endtask

  task automatic lrd(input string nm, input logic [7:0] op, input logic [7:0] e);
    logic [7:0] x;
    i_fsr_host_model.xfer({op, 16'h0000}, 16, x);
    chk(nm, {24'h000000, e}, {24'h000000, x});
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    rc("sr1p", FSR_ADDR_SR1P, 32'h0000_0000);
    chk("slverr ok", 32'h0000_0000, {31'h0, serr});
    rc("sr1w", FSR_ADDR_SR1W, 32'h0000_0000);
    rc("sr2w", FSR_ADDR_SR2W, 32'h0000_0000);
    chk("allow", 32'h0000_0000, {31'h0, wallow});
    rc("unmapped", 8'h20, 32'h0000_0000);
    chk("slverr", 32'h0000_0001, {31'h0, serr});
    lrd("link sr1", FSR_OP_READ_SR1, 8'h00);
  endtask

  task automatic t_write();
    wr(FSR_ADDR_ISTAT, 32'h0000_001F);
    lk({FSR_OP_WRITE_REGS, 16'hFF00}, 24);
    rc("refused", FSR_ADDR_SR1P, 32'h0000_0000);
    lk({FSR_OP_ALLOW, 16'h0000}, 8);
    chk("allow", 32'h0000_0001, {31'h0, wallow});
    lk({FSR_OP_WRITE_REGS, 16'hFF00}, 24);
    rc("sr1p", FSR_ADDR_SR1P, 32'h0000_009C);
    rc("sr1w", FSR_ADDR_SR1W, 32'h0000_009E);
    rc("istat", FSR_ADDR_ISTAT, 32'h0000_0007);
    chk("range", 32'h0000_0007, {29'h0, prange});
    lrd("link sr1", FSR_OP_READ_SR1, 8'h9E);
  endtask

  task automatic t_lock();
    @(posedge clk);
    wp_n <= 1'b0;
    lk({FSR_OP_WRITE_REGS, 16'h0000}, 24);
    rc("locked", FSR_ADDR_SR1P, 32'h0000_009C);
    @(posedge clk);
    wp_n <= 1'b1;
    lk({FSR_OP_WRITE_REGS, 16'h0800}, 24);
    rc("unlocked", FSR_ADDR_SR1W, 32'h0000_000A);
    @(posedge clk);
    wp_n <= 1'b0;
    lk({FSR_OP_WRITE_REGS, 16'h1000}, 24);
    rc("no lock", FSR_ADDR_SR1P, 32'h0000_0010);
    chk("range", 32'h0000_0004, {29'h0, prange});
  endtask

  task automatic t_forbid();
    lk({FSR_OP_FORBID, 16'h0000}, 8);
    chk("forbid", 32'h0000_0000, {31'h0, wallow});
    lk({FSR_OP_WRITE_REGS, 16'h1C00}, 24);
    rc("ignored", FSR_ADDR_SR1P, 32'h0000_0010);
  endtask

  task automatic t_engine();
    wr(FSR_ADDR_ENGINE, 32'h0000_0007);
    rc("busy", FSR_ADDR_SR1W, 32'h0000_0011);
    rc("holds", FSR_ADDR_SR2W, 32'h0000_0003);
    lrd("link sr2", FSR_OP_READ_SR2, 8'h03);
    wr(FSR_ADDR_ENGINE, 32'h0000_0000);
    rc("idle", FSR_ADDR_SR2W, 32'h0000_0000);
    wr(FSR_ADDR_EVENT, 32'h0000_0003);
    rc("errs", FSR_ADDR_SR1W, 32'h0000_0070);
    wr(FSR_ADDR_SR1W, 32'h0000_00FF);
    rc("sr1w ro", FSR_ADDR_SR1W, 32'h0000_0070);
    wr(FSR_ADDR_EVENT, 32'h0000_000C);
    rc("errs clr", FSR_ADDR_SR1W, 32'h0000_0010);
    wr(FSR_ADDR_EVENT, 32'h0000_0030);
    rc("eval ok", FSR_ADDR_SR2W, 32'h0000_0004);
    wr(FSR_ADDR_EVENT, 32'h0000_0010);
    rc("eval not", FSR_ADDR_SR2W, 32'h0000_0000);
    wr(FSR_ADDR_SR2W, 32'h0000_00FF);
    rc("sr2 ro", FSR_ADDR_SR2W, 32'h0000_0000);
  endtask

  task automatic t_irq();
    chk("irq masked", 32'h0000_0000, {31'h0, irq});
    wr(FSR_ADDR_IMASK, 32'h0000_0018);
    repeat (2) @(posedge clk);
    chk("irq on", 32'h0000_0001, {31'h0, irq});
    wr(FSR_ADDR_ISTAT, 32'h0000_0018);
    repeat (2) @(posedge clk);
    chk("irq off", 32'h0000_0000, {31'h0, irq});
    rc("istat", FSR_ADDR_ISTAT, 32'h0000_0007);
  endtask

  task automatic t_volatile();
    wr(FSR_ADDR_CFG1, 32'h0000_0008);
    rc("forced", FSR_ADDR_SR1P, 32'h0000_001C);
    chk("range kept", 32'h0000_0004, {29'h0, prange});
    lk({FSR_OP_ALLOW, 16'h0000}, 8);
    lk({FSR_OP_WRITE_REGS, 16'h0400}, 24);
    rc("nv kept", FSR_ADDR_SR1P, 32'h0000_001C);
    rc("working", FSR_ADDR_SR1W, 32'h0000_0006);
    chk("range", 32'h0000_0001, {29'h0, prange});
    wr(FSR_ADDR_CFG1, 32'h0000_0000);
    rc("cfg", FSR_ADDR_CFG1, 32'h0000_0008);
  endtask

  // ==========================================================================
  // Sequence and watchdog
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_write();
    t_lock();
    t_forbid();
    t_engine();
    t_irq();
    t_volatile();
    end_of_test();
  end

  // About 4200 cycles expected; allow several times that before giving up
  initial
  begin
    #400000;
    err_total++;
    end_of_test();
  end
endmodule
